/* hdl/asl_decoder.v */
// Decode and execute of add-and-skip, logical AND and bit-AND-into-carry
// Overview of operation
// - 1010+imm byte adds immediate to nibble accumulator, 1 cycle plus skip.
// - 0xc9 then byte adds immediate to extended accumulator, 2 cycles plus skip.
// - 0x3f adds memory nibble at pointer pair to nibble accumulator.
// - 0xdc, 10011 rr 0 adds register pair into extended accumulator.
// - 0xdc, 10010 rr 0 adds extended accumulator into register pair.
// - Add-and-skip stores sum, keeps source, skips on carry out, carry untouched.
// - Indirect add-with-carry overflow skips a following nibble immediate add.
// - That following nibble immediate add never raises its own skip.
// - AND writes bitwise AND into destination, source unchanged.
// - 0xdd, 0001 imm ANDs immediate into nibble accumulator, 2 cycles.
// - 0x39 ANDs memory nibble at pointer pair into nibble accumulator.
// - 0xdc, 00011 rr 0 ANDs register pair into extended accumulator.
// - 0xdc, 00010 rr 0 ANDs extended accumulator into register pair.
// - Bit-AND clears carry when source bit is zero, never alters source.
// - Bit-AND is 0xf5 plus 0100 a5..a2 or 00/10/11 bb a3..a0, 2 cycles.
// - L-indexed form forms address from a5..a2 with L3..2, bit L1..0.
// - Page form uses H (00), 0xb (10) or 0xf (11) as high nibble, a3..a0 low, bit from bb.
`timescale 1ns/1ps
`include "asl_map.vh"
module asl_decoder (
  input wire ref_clk,
  input wire reset,
  input wire ins_valid,
  input wire [7:0] ins_byte,
  output wire ins_ready,
  input wire [3:0] reg_h,
  input wire [3:0] reg_l,
  input wire [7:0] hl_addr,
  output reg [7:0] mem_addr,
  input wire [3:0] mem_rdata,
  input wire carry_in,
  output reg carry_out,
  output reg carry_we,
  output reg [7:0] ext_acc,
  output reg skip,
  output reg busy,
  output reg unknown_op
);
  localparam S_OP = 4'b0001;
  localparam S_B2 = 4'b0010;
  localparam S_EX = 4'b0100;
  localparam S_SKIP = 4'b1000;
  reg [3:0] state_r;
  reg [7:0] op_r;
  reg [7:0] b2_r;
  reg adc_carry_r;
  reg adc_pend_r;
  reg skip_pend_r;
  reg skip_len2_r;
  wire [7:0] pair_rd;
  reg pair_we;
  reg [7:0] pair_wd;
  wire [1:0] pair_sel = b2_r[2:1];
  wire [3:0] acc_nib = ext_acc[3:0];
  wire [4:0] sum_nib_im = {1'b0, acc_nib} + {1'b0, op_r[3:0]};
  wire [4:0] sum_nib_mem = {1'b0, acc_nib} + {1'b0, mem_rdata};
  wire [4:0] sum_adc = {1'b0, acc_nib} + {1'b0, mem_rdata} + {4'h0, carry_in};
  wire [8:0] sum_imm = {1'b0, ext_acc} + {1'b0, b2_r};
  wire [8:0] sum_pair = {1'b0, ext_acc} + {1'b0, pair_rd};
  wire is_band_l = b2_r[7:4] == `ASL_B2_BAND_L;
  wire [1:0] band_bit = is_band_l ? reg_l[1:0] : b2_r[5:4];
  // Read data are registered, so the select must come from the byte being taken
  wire [1:0] rd_pick = (state_r == S_B2) ? ins_byte[2:1] : b2_r[2:1];
  wire op_len2 = (ins_byte == `ASL_OP_ADS_EA_IMM) || (ins_byte == `ASL_OP_PAIR) ||
    (ins_byte == `ASL_OP_AND_IM) || (ins_byte == `ASL_OP_BAND);
  // Only a nibble immediate add is swallowed by an overflowing add-with-carry
  wire adc_swallow = adc_pend_r && adc_carry_r && (ins_byte[7:4] == `ASL_OP_ADS_IM_HI);
  assign ins_ready = (state_r == S_OP) || (state_r == S_B2) || (state_r == S_SKIP);

  asl_regfile #(.NPAIR(4), .AW(2)) u_pairs (
    .ref_clk(ref_clk),
    .reset(reset),
    .rd_sel(rd_pick),
    .rd_data(pair_rd),
    .wr_en(pair_we),
    .wr_sel(pair_sel),
    .wr_data(pair_wd)
  );

  // Memory address follows the operand form; the data come back combinationally
  always @* begin
    mem_addr = hl_addr;
    if (op_r == `ASL_OP_BAND) begin
      if (is_band_l)
        mem_addr = {`ASL_MEMB_HI, b2_r[3:0], reg_l[3:2]};
      else if (b2_r[7:6] == `ASL_B2_BAND_H)
        mem_addr = {reg_h, b2_r[3:0]};
      else if (b2_r[7:6] == `ASL_B2_BAND_FB)
        mem_addr = {`ASL_PAGE_FB, b2_r[3:0]};
      else
        mem_addr = {`ASL_PAGE_FF, b2_r[3:0]};
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      state_r <= S_OP;
      op_r <= 8'h00;
      b2_r <= 8'h00;
      ext_acc <= 8'h00;
      skip <= 1'b0;
      busy <= 1'b0;
      unknown_op <= 1'b0;
      carry_out <= 1'b0;
      carry_we <= 1'b0;
      adc_carry_r <= 1'b0;
      adc_pend_r <= 1'b0;
      skip_pend_r <= 1'b0;
      skip_len2_r <= 1'b0;
      pair_we <= 1'b0;
      pair_wd <= 8'h00;
    end else begin
      skip <= 1'b0;
      carry_we <= 1'b0;
      pair_we <= 1'b0;
      unknown_op <= 1'b0;
      case (state_r)
        S_OP: begin
          busy <= 1'b0;
          if (ins_valid) begin
            op_r <= ins_byte;
            adc_pend_r <= 1'b0;
            if (skip_pend_r || adc_swallow) begin
              // Fetch and discard; two-byte opcodes also consume their second byte
              skip_pend_r <= 1'b0;
              skip_len2_r <= op_len2;
              state_r <= op_len2 ? S_SKIP : S_OP;
              busy <= op_len2;
              skip <= adc_swallow;
            end else if (ins_byte[7:4] == `ASL_OP_ADS_IM_HI) begin
              ext_acc[3:0] <= acc_nib + ins_byte[3:0];
              if (!adc_pend_r && ({1'b0, acc_nib} + {1'b0, ins_byte[3:0]} > 5'h0f)) begin
                skip <= 1'b1;
                skip_pend_r <= 1'b1;
              end
            end else if (ins_byte == `ASL_OP_ADS_A_HL || ins_byte == `ASL_OP_AND_A_HL ||
                         ins_byte == `ASL_OP_ADC_A_HL) begin
              state_r <= S_EX;
              busy <= 1'b1;
            end else if (ins_byte == `ASL_OP_ADS_EA_IMM || ins_byte == `ASL_OP_PAIR ||
                         ins_byte == `ASL_OP_AND_IM || ins_byte == `ASL_OP_BAND) begin
              state_r <= S_B2;
              busy <= 1'b1;
            end else begin
              unknown_op <= 1'b1;
            end
          end
        end
        S_B2: begin
          if (ins_valid) begin
            b2_r <= ins_byte;
            state_r <= S_EX;
          end
        end
        S_EX: begin
          state_r <= S_OP;
          busy <= 1'b0;
          case (op_r)
            `ASL_OP_ADS_A_HL: begin
              ext_acc[3:0] <= sum_nib_mem[3:0];
              skip <= sum_nib_mem[4];
              skip_pend_r <= sum_nib_mem[4];
            end
            `ASL_OP_AND_A_HL: ext_acc[3:0] <= acc_nib & mem_rdata;
            `ASL_OP_ADC_A_HL: begin
              ext_acc[3:0] <= sum_adc[3:0];
              carry_out <= sum_adc[4];
              carry_we <= 1'b1;
              // Overflow is held for the next byte; any other instruction runs normally
              adc_carry_r <= sum_adc[4];
              adc_pend_r <= 1'b1;
            end
            `ASL_OP_ADS_EA_IMM: begin
              ext_acc <= sum_imm[7:0];
              skip <= sum_imm[8];
              skip_pend_r <= sum_imm[8];
            end
            `ASL_OP_AND_IM: begin
              if (b2_r[7:4] == `ASL_B2_AND_IM_HI)
                ext_acc[3:0] <= acc_nib & b2_r[3:0];
              else
                unknown_op <= 1'b1;
            end
            `ASL_OP_PAIR: begin
              if (b2_r[0] != 1'b0) begin
                unknown_op <= 1'b1;
              end else if (b2_r[7:3] == `ASL_B2_ADS_EA_RR) begin
                ext_acc <= sum_pair[7:0];
                skip <= sum_pair[8];
                skip_pend_r <= sum_pair[8];
              end else if (b2_r[7:3] == `ASL_B2_ADS_RR_EA) begin
                pair_wd <= sum_pair[7:0];
                pair_we <= 1'b1;
                skip <= sum_pair[8];
                skip_pend_r <= sum_pair[8];
              end else if (b2_r[7:3] == `ASL_B2_AND_EA_RR) begin
                ext_acc <= ext_acc & pair_rd;
              end else if (b2_r[7:3] == `ASL_B2_AND_RR_EA) begin
                pair_wd <= ext_acc & pair_rd;
                pair_we <= 1'b1;
              end else begin
                unknown_op <= 1'b1;
              end
            end
            `ASL_OP_BAND: begin
              // Carry only ever cleared here; the source bit is just read
              if (b2_r[7:4] == `ASL_B2_BAND_L || b2_r[7:6] != 2'b01) begin
                carry_out <= carry_in & mem_rdata[band_bit];
                carry_we <= 1'b1;
              end else begin
                unknown_op <= 1'b1;
              end
            end
            default: unknown_op <= 1'b1;
          endcase
        end
        S_SKIP: begin
          // Second byte of a discarded two-byte instruction
          if (!skip_len2_r) begin
            state_r <= S_OP;
            busy <= 1'b0;
          end else if (ins_valid) begin
            skip_len2_r <= 1'b0;
            state_r <= S_OP;
            busy <= 1'b0;
          end
        end
        default: state_r <= S_OP;
      endcase
    end
  end
endmodule // asl_decoder

/* hdl/asl_map.vh */
// Opcode encodings and field positions for the add-skip and logic decoder
`ifndef ASL_MAP_VH
`define ASL_MAP_VH
`define ASL_OP_ADS_IM_HI 4'ha
`define ASL_OP_ADS_EA_IMM 8'hc9
`define ASL_OP_ADS_A_HL 8'h3f
`define ASL_OP_PAIR 8'hdc
`define ASL_OP_AND_IM 8'hdd
`define ASL_OP_AND_A_HL 8'h39
`define ASL_OP_ADC_A_HL 8'h3e
`define ASL_OP_BAND 8'hf5
`define ASL_B2_ADS_EA_RR 5'h13
`define ASL_B2_ADS_RR_EA 5'h12
`define ASL_B2_AND_EA_RR 5'h03
`define ASL_B2_AND_RR_EA 5'h02
`define ASL_B2_AND_IM_HI 4'h1
`define ASL_B2_BAND_L 4'h4
`define ASL_B2_BAND_H 2'h0
`define ASL_B2_BAND_FB 2'h2
`define ASL_B2_BAND_FF 2'h3
`define ASL_PAGE_FB 4'hb
`define ASL_PAGE_FF 4'hf
`define ASL_ADDR_HI_F 4'hf
`define ASL_MEMB_HI 2'h3
`endif

/* hdl/asl_regfile.v */
// Register pair storage for the decoder: four 8-bit pairs
`timescale 1ns/1ps
module asl_regfile #(
  parameter NPAIR = 4,
  parameter AW = 2
) (
  input wire ref_clk,
  input wire reset,
  input wire [AW-1:0] rd_sel,
  output reg [7:0] rd_data,
  input wire wr_en,
  input wire [AW-1:0] wr_sel,
  input wire [7:0] wr_data
);
  reg [7:0] mem [0:NPAIR-1];
  integer i;
  always @(posedge ref_clk) begin
    if (reset) begin
      for (i = 0; i < NPAIR; i = i + 1) begin
        mem[i] <= 8'h00;
      end
    end else if (wr_en) begin
      mem[wr_sel] <= wr_data;
    end
  end
  // Registered read: data for a select appears one cycle later
  always @(posedge ref_clk) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= (wr_en && wr_sel == rd_sel) ? wr_data : mem[rd_sel];
    end
  end
endmodule // asl_regfile

/* dv/asl_decoder_props.sv */
// Port-level timing checks for the add-skip and logic decoder
`timescale 1ns/1ps
module asl_decoder_props (
  input wire ref_clk,
  input wire reset,
  input wire ins_valid,
  input wire ins_ready,
  input wire carry_we,
  input wire [7:0] ext_acc,
  input wire skip,
  input wire unknown_op
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire take = ins_valid & ins_ready;
  a_reset_clear: assert property ($fell(reset) |-> ext_acc == 8'h00 && !skip && !carry_we)
    else $error("outputs not cleared by reset");
  a_skip_single: assert property (skip |=> !skip)
    else $error("skip pulse too long");
  a_carry_single: assert property (carry_we |=> !carry_we)
    else $error("carry write pulse too long");
  a_acc_quiet: assert property ((!take) [*3] |=> $stable(ext_acc))
    else $error("accumulator moved with no instruction");
  a_skip_cause: assert property (skip |-> $past(take) || $past(take, 2))
    else $error("skip without an instruction");
  a_carry_cause: assert property (carry_we |-> $past(take) || $past(take, 2))
    else $error("carry write without an instruction");
  a_acc_cause: assert property (!$stable(ext_acc) |-> $past(take) || $past(take, 2))
    else $error("accumulator write without an instruction");
  a_unknown_cause: assert property (unknown_op |-> $past(take) || $past(take, 2))
    else $error("unknown flag without a byte");
  a_skip_no_carry: assert property (skip |-> !carry_we)
    else $error("skip pulse came with a carry write");
endmodule // asl_decoder_props
bind asl_decoder asl_decoder_props u_props (.ref_clk(ref_clk), .reset(reset), .ins_valid(ins_valid),
  .ins_ready(ins_ready), .carry_we(carry_we), .ext_acc(ext_acc), .skip(skip), .unknown_op(unknown_op));

/* dv/testbench.sv */
// Self-checking bench for the add-skip and logic decoder
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 0, reset = 1, ins_valid = 0, carry_in = 0;
  logic [7:0] ins_byte = 0, hl_addr = 0;
  logic [3:0] reg_h = 0, reg_l = 0;
  wire [3:0] mem_rdata;
  wire ins_ready, carry_out, carry_we, skip, busy, unknown_op;
  wire [7:0] mem_addr, ext_acc;
  int err_count = 0, total_checks = 0;
  int acc, pend, adc, i, r, sel;
  int skips_seen = 0, skips_exp = 0;
  int pr[4];
  logic [7:0] bexp;
  asl_decoder uut (.ref_clk(ref_clk), .reset(reset), .ins_valid(ins_valid), .ins_byte(ins_byte),
    .ins_ready(ins_ready), .reg_h(reg_h), .reg_l(reg_l), .hl_addr(hl_addr), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .carry_in(carry_in), .carry_out(carry_out), .carry_we(carry_we),
    .ext_acc(ext_acc), .skip(skip), .busy(busy), .unknown_op(unknown_op));
  // Memory image derived from the address, so a wrong address shows up as wrong data
  assign mem_rdata = mem_addr[3:0] ^ mem_addr[7:4];
  initial forever #25 ref_clk = ~ref_clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Valid is left high so back-to-back bytes need no second assignment in one step
  task automatic put(input logic [7:0] b);
    int n;
    ins_valid = 1;
    ins_byte = b;
    for (n = 0; n < 20 && ins_ready !== 1'b1; n++) @(posedge ref_clk) #1;
    @(posedge ref_clk) #1;
  endtask
  task automatic ins(input logic [7:0] b0, input logic [7:0] b1, input int n, input int idle);
    int s, sp, m, k;
    logic [7:0] ba;
    logic [1:0] bb;
    put(b0);
    if (n == 2) put(b1);
    s = 0; sp = 0; k = b1[2:1];
    m = hl_addr[3:0] ^ hl_addr[7:4];
    if (pend) adc = 0;
    else begin
      if (b0[7:4] == 4'ha) begin s = (acc & 15) + b0[3:0]; sp = s > 15 && !adc; acc = acc & 240 | s & 15; end
      else if (b0 == 8'hc9) begin s = acc + b1; sp = s > 255; acc = s & 255; end
      else if (b0 == 8'h3f) begin s = (acc & 15) + m; sp = s > 15; acc = acc & 240 | s & 15; end
      else if (b0 == 8'h3e) begin s = (acc & 15) + m + carry_in; sp = s > 15; acc = acc & 240 | s & 15; bexp = {7'h00, sp[0]}; end
      else if (b0 == 8'hdd) acc = acc & (240 | b1[3:0]);
      else if (b0 == 8'h39) acc = acc & (240 | m);
      else if (b0 == 8'hf5) begin
        ba = {reg_h, b1[3:0]};
        bb = b1[5:4];
        if (b1[7:4] == 4'h4) begin ba = {2'b11, b1[3:0], reg_l[3:2]}; bb = reg_l[1:0]; end
        else if (b1[7]) ba[7:4] = b1[6] ? 4'hf : 4'hb;
        m = ba[3:0] ^ ba[7:4];
        bexp = {7'h00, carry_in & m[bb]};
      end else case (b1[7:3])
        5'h13: begin s = acc + pr[k]; sp = s > 255; acc = s & 255; end
        5'h12: begin s = acc + pr[k]; sp = s > 255; pr[k] = s & 255; end
        5'h03: acc = acc & pr[k];
        default: pr[k] = pr[k] & acc;
      endcase
      adc = (b0 == 8'h3e) && !sp;
    end
    pend = sp;
    skips_exp += sp;
    if (idle) begin
      ins_valid = 0;
      repeat (3) @(posedge ref_clk) #1;
      check(ext_acc, acc[7:0], "ext_acc");
      check(skips_seen[7:0], skips_exp[7:0], "skip count");
      check({6'h00, busy, ins_ready}, 8'h01, "busy ready");
    end
  endtask
  always @(posedge ref_clk) begin
    if (carry_we === 1'b1) check({7'h00, carry_out}, bexp, "carry");
    if (!reset && skip === 1'b1) skips_seen++;
    if (!reset && unknown_op !== 1'b0) check({7'h00, unknown_op}, 8'h00, "unknown_op");
  end
  initial begin
    #1000000;
    err_count++;
    finish_test;
  end
  initial begin
    r = $urandom(29);
    acc = 0; pend = 0; adc = 0;
    repeat (8) @(posedge ref_clk);
    #1 reset = 0;
    check(ext_acc, 8'h00, "ext_acc reset");
    for (i = 0; i < 24; i++) begin
      hl_addr = $urandom;
      reg_h = $urandom;
      reg_l = $urandom;
      carry_in = $urandom;
      r = $urandom;
      sel = r[1:0];
      ins({4'ha, r[3:0]}, 8'h00, 1, 0);
      ins(8'hc9, r[15:8], 2, 0);
      ins(8'h3f, 8'h00, 1, 1);
      ins(8'hdc, {5'h12, sel[1:0], 1'b0}, 2, 1);
      ins(8'hdc, {5'h13, sel[1:0], 1'b0}, 2, 1);
      ins(8'hdc, {5'h03, sel[1:0], 1'b0}, 2, 1);
      ins(8'hdc, {5'h02, r[9:8], 1'b0}, 2, 1);
      ins(8'hdd, {4'h1, r[19:16]}, 2, 1);
      ins(8'h39, 8'h00, 1, 1);
      ins(8'hf5, {2'b00, r[21:20], r[27:24]}, 2, 1);
      ins(8'hf5, {4'h4, r[23:20]}, 2, 1);
      ins(8'hf5, {1'b1, r[24], r[21:20], r[27:24]}, 2, 1);
      ins(8'h3e, 8'h00, 1, 0);
      ins({4'ha, r[31:28]}, 8'h00, 1, 0);
      ins(8'hc9, r[7:0], 2, 1);
    end
    finish_test;
  end
endmodule // testbench
